// >>> hdl/ebrw_defs.svh
// Purpose: register offsets, field positions and reset values
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   included by the bus wait controller
`ifndef EBRW_DEFS_SVH
`define EBRW_DEFS_SVH
`define EBRW_OFS_CFG       8'h00
`define EBRW_OFS_ADDR      8'h04
`define EBRW_OFS_WDATA     8'h08
`define EBRW_OFS_CMD       8'h0C
`define EBRW_OFS_STATUS    8'h10
`define EBRW_OFS_RDATA     8'h14
`define EBRW_CFG_RDY_EN    0
`define EBRW_CFG_ASYNC     1
`define EBRW_CFG_MUX       2
`define EBRW_CFG_TRI       3
`define EBRW_CFG_MCW_LO    4
`define EBRW_CFG_MCW_HI    7
`define EBRW_CMD_READ      0
`define EBRW_CMD_LO        1
`define EBRW_CMD_HI        2
`define EBRW_CFG_RESET     8'h00
`define EBRW_WCNT_MAX      8'hFF
`endif

// >>> hdl/ebrw_pkg.sv
// Purpose: types of the bus wait controller
// Assumes: nothing
// Notes:   all state of the controller is one packed struct
package ebrw_pkg;
    typedef enum logic [2:0] {
        EBRW_IDLE,
        EBRW_ADDR,
        EBRW_CMD,
        EBRW_MUXW,
        EBRW_TRIW
    } ebrw_state_e;
    typedef struct packed {
        logic        pend;
        logic        ph;
        ebrw_state_e st;
        logic [3:0]  cnt;
        logic        waited;
        logic        rd_cyc;
        logic        be_lo;
        logic        be_hi;
        logic [7:0]  cfg;
        logic [15:0] addr;
        logic [15:0] wdat;
        logic [15:0] rdat;
        logic        done;
        logic [7:0]  wcnt;
        logic [7:0]  lastw;
        logic        rs1;
        logic        rs2;
        logic [15:0] ds1;
        logic [15:0] ds2;
        logic        ale;
        logic        rd_n;
        logic        wrl_n;
        logic        wrh_n;
        logic        rcs_n;
        logic        wcs_n;
        logic        bhe_n;
        logic [15:0] a_o;
        logic [15:0] d_o;
        logic        d_oe;
        logic        rdy;
        logic [31:0] rdata;
        logic        slverr;
    } ebrw_state_s;
endpackage

// >>> hdl/ebrw_ctrl.sv
// Purpose: external bus cycle controller with wait-request handling
// Assumes: pclk 10 MHz; the bus reference clock is pclk divided by 2
// Notes:   all pin inputs pass two flip-flops before use
`timescale 1ns/100ps
`include "ebrw_defs.svh"

// Notes on behaviour
// - external logic stretches each bus cycle with wait request enabled through the wait-request pin, sampled to decide continuation.
// - asynchronous mode forces a first wait state, costing at least one wait state per controlled cycle.
// - a high sample at the sampling point inserts one more wait state and samples again.
// - a low sample at the sampling point ends the running bus cycle.
// - the programmed length with its memory-cycle wait states runs out before sampling may end the cycle.
// - multiplexed cycles get a multiplexing wait state afterwards, optionally followed by a tristate wait state.
// - the gap after a cycle is two reference clocks for multiplexed with tristate and zero for plain demultiplexed.
// - the next first sampling point follows from this tristate state and the next memory-cycle and latch modes.
// - a multiplexed cycle gives the far side one extra reference clock to withdraw the wait level.
// - read data are caught on the edge that raises the read strobe, which leaves the address unchanged.
// - the address stays put until the write strobes are high again.
module ebrw_ctrl
    import ebrw_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             bus_ref_clock_out,
    input  wire logic        bus_ready_n,
    output logic             ale,
    output logic             read_n,
    output logic             write_low_byte_n,
    output logic             write_high_byte_n,
    output logic             read_chip_sel_n,
    output logic             write_chip_sel_n,
    output logic             high_byte_enable_n,
    output logic [15:0]      addr_out,
    output logic [15:0]      data_out,
    output logic             data_oe,
    input  wire logic [15:0] data_in
);

    //****************************************************************
    // state
    //****************************************************************
    // s is the whole registered state, next_s the value it takes next
    ebrw_state_s s;
    ebrw_state_s next_s;

    logic tick;
    logic access;
    logic wr_ok;
    logic busy;
    logic sample_ok;
    logic [3:0] mcw;

    // every bus pin changes only on a tick, the pclk edge on which the
    // reference clock rises, so the far side can time itself on that clock
    // alone; the apb side runs on every pclk
    // rising edge of the reference clock comes next cycle
    assign tick = ~s.ph;
    assign access = psel & penable;
    assign wr_ok = access & pwrite & s.rdy;
    assign busy = s.pend | (s.st != EBRW_IDLE);
    assign mcw = s.cfg[`EBRW_CFG_MCW_HI:`EBRW_CFG_MCW_LO];

    // the pin passes the two-stage synchroniser in both modes, so both see
    // the same two pclk of latency; async only adds the forced first wait
    // low sample ends; async needs one forced wait first
    assign sample_ok = ~s.rs2 & (~s.cfg[`EBRW_CFG_ASYNC] | s.waited);

    //****************************************************************
    // next state
    //****************************************************************
    always_comb begin
        next_s = s;
        next_s.ph = ~s.ph;
        // two-stage synchronisers for pin inputs
        next_s.rs1 = bus_ready_n;
        next_s.rs2 = s.rs1;
        next_s.ds1 = data_in;
        next_s.ds2 = s.ds1;

        // the answer stands one pclk: the second access cycle sees rdy high
        // and lets it fall, so each transfer gives exactly one pready pulse
        // apb: answer one cycle into the access phase
        next_s.rdy = access & ~s.rdy;
        next_s.slverr = 1'b0;
        next_s.rdata = 32'h0000_0000;
        if (access & ~s.rdy) begin
            case (paddr)
                `EBRW_OFS_CFG: begin
                    next_s.rdata = {24'h00_0000, s.cfg};
                end
                `EBRW_OFS_ADDR: begin
                    next_s.rdata = {16'h0000, s.addr};
                end
                `EBRW_OFS_WDATA: begin
                    next_s.rdata = {16'h0000, s.wdat};
                end
                `EBRW_OFS_CMD: begin
                    next_s.rdata = 32'h0000_0000;
                end
                `EBRW_OFS_STATUS: begin
                    next_s.rdata = {16'h0000, s.lastw, 6'h00, s.done, busy};
                end
                `EBRW_OFS_RDATA: begin
                    next_s.rdata = {16'h0000, s.rdat};
                end
                default: begin
                    next_s.slverr = 1'b1;
                end
            endcase
        end

        // a command that arrives while a cycle runs is dropped without an
        // error; software polls busy in status before it issues the next one
        // register writes take effect at the edge with pready high
        if (wr_ok) begin
            case (paddr)
                `EBRW_OFS_CFG: begin
                    next_s.cfg = pwdata[7:0];
                end
                `EBRW_OFS_ADDR: begin
                    next_s.addr = pwdata[15:0];
                end
                `EBRW_OFS_WDATA: begin
                    next_s.wdat = pwdata[15:0];
                end
                `EBRW_OFS_CMD: begin
                    if (!busy) begin
                        next_s.pend = 1'b1;
                        next_s.done = 1'b0;
                        next_s.rd_cyc = pwdata[`EBRW_CMD_READ];
                        next_s.be_lo = pwdata[`EBRW_CMD_LO];
                        next_s.be_hi = pwdata[`EBRW_CMD_HI];
                    end
                end
                default: begin
                    next_s.pend = s.pend;
                end
            endcase
        end

        // idle waits for a command; addr drives the shared lines while the
        // latch pulse is high; cmd holds the strobes through the programmed
        // and the requested waits; muxw and triw are the gaps after a cycle
        // in which the far side releases the shared lines and its wait level
        // bus sequencer, advances on reference clock rising edges
        if (tick) begin
            case (s.st)
                EBRW_IDLE: begin
                    if (s.pend) begin
                        // wait counters restart for every cycle
                        next_s.pend = 1'b0;
                        next_s.waited = 1'b0;
                        next_s.wcnt = 8'h00;
                        next_s.a_o = s.addr;
                        next_s.bhe_n = ~s.be_hi;
                        if (s.cfg[`EBRW_CFG_MUX]) begin
                            // address phase on the shared lines
                            next_s.ale = 1'b1;
                            next_s.d_o = s.addr;
                            next_s.d_oe = 1'b1;
                            next_s.st = EBRW_ADDR;
                        end else begin
                            // demultiplexed: strobes fall at once with the address
                            next_s.rd_n = ~s.rd_cyc;
                            next_s.rcs_n = ~s.rd_cyc;
                            next_s.wrl_n = s.rd_cyc | ~s.be_lo;
                            next_s.wrh_n = s.rd_cyc | ~s.be_hi;
                            next_s.wcs_n = s.rd_cyc;
                            next_s.d_o = s.wdat;
                            next_s.d_oe = ~s.rd_cyc;
                            next_s.cnt = mcw;
                            next_s.st = EBRW_CMD;
                        end
                    end
                end
                EBRW_ADDR: begin
                    // latch pulse over: strobes fall, write data replace the address
                    next_s.ale = 1'b0;
                    next_s.rd_n = ~s.rd_cyc;
                    next_s.rcs_n = ~s.rd_cyc;
                    next_s.wrl_n = s.rd_cyc | ~s.be_lo;
                    next_s.wrh_n = s.rd_cyc | ~s.be_hi;
                    next_s.wcs_n = s.rd_cyc;
                    next_s.d_o = s.wdat;
                    next_s.d_oe = ~s.rd_cyc;
                    next_s.cnt = mcw;
                    next_s.st = EBRW_CMD;
                end
                EBRW_CMD: begin
                    // a cycle whose wait request is disabled ends right after the
                    // programmed wait states, whatever the pin shows
                    if (s.cnt != 4'h0) begin
                        // programmed memory-cycle wait states first
                        next_s.cnt = s.cnt - 4'h1;
                    end else if (s.cfg[`EBRW_CFG_RDY_EN] & ~sample_ok) begin
                        // high sample: one more wait, sample again
                        next_s.waited = 1'b1;
                        if (s.wcnt != `EBRW_WCNT_MAX) begin
                            next_s.wcnt = s.wcnt + 8'h01;
                        end
                    end else begin
                        // end of cycle: strobes rise, data caught here
                        next_s.rd_n = 1'b1;
                        next_s.rcs_n = 1'b1;
                        next_s.wrl_n = 1'b1;
                        next_s.wrh_n = 1'b1;
                        next_s.wcs_n = 1'b1;
                        if (s.rd_cyc) begin
                            next_s.rdat = s.ds2;
                        end
                        // address output left as is until the next cycle
                        next_s.a_o = s.a_o;
                        next_s.lastw = s.wcnt;
                        next_s.done = 1'b1;
                        if (s.cfg[`EBRW_CFG_MUX]) begin
                            next_s.st = EBRW_MUXW;
                        end else if (s.cfg[`EBRW_CFG_TRI]) begin
                            next_s.st = EBRW_TRIW;
                        end else begin
                            next_s.st = EBRW_IDLE;
                        end
                    end
                end
                EBRW_MUXW: begin
                    // data lines released one tick after the strobes rose
                    // extra clock for the far side to drop its wait level
                    next_s.d_oe = 1'b0;
                    if (s.cfg[`EBRW_CFG_TRI]) begin
                        next_s.st = EBRW_TRIW;
                    end else begin
                        next_s.st = EBRW_IDLE;
                    end
                end
                EBRW_TRIW: begin
                    // optional gap after muxw, or straight after a demultiplexed cycle; one more tick with the lines released
                    // gap moves the next first sampling point later
                    next_s.d_oe = 1'b0;
                    next_s.st = EBRW_IDLE;
                end
                default: begin
                    next_s.st = EBRW_IDLE;
                end
            endcase
        end
    end

    //****************************************************************
    // registers
    //****************************************************************
    // the reset image keeps every strobe inactive and the shared lines
    // released, so the far side sees no cycle until a command is issued
    // all state frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{
                pend: 1'b0, ph: 1'b0, st: EBRW_IDLE, cnt: 4'h0,
                waited: 1'b0, rd_cyc: 1'b0, be_lo: 1'b0, be_hi: 1'b0,
                cfg: `EBRW_CFG_RESET, addr: 16'h0000, wdat: 16'h0000,
                rdat: 16'h0000, done: 1'b0, wcnt: 8'h00, lastw: 8'h00,
                rs1: 1'b1, rs2: 1'b1, ds1: 16'h0000, ds2: 16'h0000,
                ale: 1'b0, rd_n: 1'b1, wrl_n: 1'b1, wrh_n: 1'b1,
                rcs_n: 1'b1, wcs_n: 1'b1, bhe_n: 1'b1, a_o: 16'h0000,
                d_o: 16'h0000, d_oe: 1'b0, rdy: 1'b0,
                rdata: 32'h0000_0000, slverr: 1'b0
            };
        end else if (ce) begin
            s <= next_s;
        end
    end

    //****************************************************************
    // outputs, all straight from flip-flops
    //****************************************************************
    // apb answer
    assign pready = s.rdy;
    assign prdata = s.rdata;
    assign pslverr = s.slverr;

    // bus pins; the reference clock runs free, also between cycles
    assign bus_ref_clock_out = s.ph;
    assign ale = s.ale;
    assign read_n = s.rd_n;
    assign write_low_byte_n = s.wrl_n;
    assign write_high_byte_n = s.wrh_n;
    assign read_chip_sel_n = s.rcs_n;
    assign write_chip_sel_n = s.wcs_n;
    assign high_byte_enable_n = s.bhe_n;
    assign addr_out = s.a_o;
    assign data_out = s.d_o;
    assign data_oe = s.d_oe;

endmodule // ebrw_ctrl

// >>> verification/ebrw_ctrl_chk.sv
// Purpose: port checks of the bus wait controller
// Assumes: config changes only between bus cycles
// Notes:   config is copied from APB writes seen at the ports
`timescale 1ns/100ps
`include "ebrw_defs.svh"
module ebrw_ctrl_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        bus_ref_clock_out,
    input wire logic        bus_ready_n,
    input wire logic        ale,
    input wire logic        read_n,
    input wire logic        write_low_byte_n,
    input wire logic        write_high_byte_n,
    input wire logic        read_chip_sel_n,
    input wire logic        write_chip_sel_n,
    input wire logic        high_byte_enable_n,
    input wire logic        data_oe,
    input wire logic [15:0] addr_out
);
    logic [7:0] cfg;
    logic [7:0] lowc;
    logic [7:0] base;
    logic       strobe_n;
    // any strobe low marks a running cycle; base is the programmed length in pclk
    assign strobe_n = read_n & write_low_byte_n & write_high_byte_n;
    assign base     = {3'h0, cfg[7:4], 1'b0} + 8'h02;
    // config copy and strobe-low length counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg  <= 8'h00;
            lowc <= 8'h00;
        end else begin
            if (psel && penable && pready && pwrite && paddr == `EBRW_OFS_CFG) cfg <= pwdata[7:0];
            lowc <= strobe_n ? 8'h00 : lowc + 8'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_end;
        $rose(strobe_n);
    endsequence
    sequence s_held_wait;
        bus_ready_n && $past(bus_ready_n) && $past(bus_ready_n, 2) && $past(bus_ready_n, 3);
    endsequence
    property p_apb_answer; $rose(penable) && psel |-> !pready ##1 pready; endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer late or early");
    property p_refclk; 1'b1 |=> bus_ref_clock_out != $past(bus_ref_clock_out); endproperty
    a_refclk: assert property (p_refclk) else $error("reference clock not toggling");
    property p_addr_hold; !(write_low_byte_n && write_high_byte_n) |=> $stable(addr_out); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved under write strobe");
    property p_prog_len; s_end |-> (cfg[0] ? lowc >= base : lowc == base); endproperty
    a_prog_len: assert property (p_prog_len) else $error("strobe length off programmed value");
    property p_async_len; s_end and (cfg[1:0] == 2'b11) |-> lowc >= base + 8'h02; endproperty
    a_async_len: assert property (p_async_len) else $error("async cycle without wait state");
    property p_wait_hold; (cfg[0] && !strobe_n) and s_held_wait |=> !strobe_n; endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("cycle ended while wait held");
    property p_mux_gap; s_end and cfg[2] |-> !ale [*4]; endproperty
    a_mux_gap: assert property (p_mux_gap) else $error("mux wait state missing");
    property p_tri_gap; s_end and (cfg[3:2] == 2'b11) |-> !ale [*6]; endproperty
    a_tri_gap: assert property (p_tri_gap) else $error("tristate wait state missing");
    // selects, byte enable and data drive follow the strobes
    property p_rd_cs; read_chip_sel_n == read_n; endproperty
    a_rd_cs: assert property (p_rd_cs) else $error("read select differs from read strobe");
    property p_wr_cs; !(write_low_byte_n && write_high_byte_n) |-> !write_chip_sel_n && data_oe; endproperty
    a_wr_cs: assert property (p_wr_cs) else $error("write strobe without select or data drive");
    property p_rd_oe; !read_n |-> !data_oe; endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("data lines driven during read");
    property p_bhe; !write_high_byte_n |-> !high_byte_enable_n; endproperty
    a_bhe: assert property (p_bhe) else $error("high byte strobe without byte enable");
endmodule // ebrw_ctrl_chk

// >>> verification/ebrw_mem_model.sv
// Purpose: external memory answering the bus strobes
// Assumes: sixteen words, wait length set by the bench
// Notes:   released data lines show a changing pattern
`timescale 1ns/100ps
module ebrw_mem_model (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        bus_ref_clock_out,
    input wire logic        read_n,
    input wire logic        write_low_byte_n,
    input wire logic        write_high_byte_n,
    input wire logic [15:0] addr_out,
    input wire logic [15:0] data_out,
    input wire logic [3:0]  wait_ticks,
    output logic            bus_ready_n,
    output logic [15:0]     data_in
);
    logic [15:0] mem [16];
    logic [15:0] last;
    logic [3:0]  cnt;
    // read data while selected, inverted stale value when released
    assign data_in = read_n ? ~last : mem[addr_out[3:0]];
    // byte writes, and wait request held for wait_ticks reference clocks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) mem[i] <= 16'h0000;
            last        <= 16'h0000;
            cnt         <= 4'h0;
            bus_ready_n <= 1'b1;
        end else begin
            last <= data_in;
            if (!write_low_byte_n) mem[addr_out[3:0]][7:0] <= data_out[7:0];
            if (!write_high_byte_n) mem[addr_out[3:0]][15:8] <= data_out[15:8];
            if (read_n && write_low_byte_n && write_high_byte_n) begin
                cnt         <= 4'h0;
                bus_ready_n <= 1'b1;
            end else if (bus_ref_clock_out) begin
                if (cnt >= wait_ticks) bus_ready_n <= 1'b0;
                else cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // ebrw_mem_model

// >>> verification/ebrw_tb_top.sv
// Purpose: self-checking bench of the bus wait controller
// Assumes: ce held high; partner memory on the bus pins
// Notes:   each scenario is one task
`timescale 1ns/100ps
`include "ebrw_defs.svh"
module ext_bus_ready_wait_control_tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, clk_out, rdy_n, ale, rd_n, wl_n, wh_n, rcs_n, wcs_n, bhe_n, oe, er;
    logic [15:0] a_o, d_o, d_i;
    logic [3:0]  wait_ticks = 4'h0;
    int          num_errors = 0, checks_done = 0, cyc = 0;
    localparam logic [7:0] mode_cfg [6] = '{8'h10, 8'h11, 8'h13, 8'h14, 8'h1C, 8'h18};
    localparam logic [3:0] mode_wait [6] = '{4'h4, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0};
    localparam logic [7:0] mode_wexp [6] = '{8'h00, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00};
    ebrw_ctrl DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .bus_ref_clock_out(clk_out), .bus_ready_n(rdy_n), .ale(ale), .read_n(rd_n),
        .write_low_byte_n(wl_n), .write_high_byte_n(wh_n), .read_chip_sel_n(rcs_n),
        .write_chip_sel_n(wcs_n), .high_byte_enable_n(bhe_n), .addr_out(a_o), .data_out(d_o),
        .data_oe(oe), .data_in(d_i));
    ebrw_mem_model u_mem (.pclk(pclk), .presetn(presetn), .bus_ref_clock_out(clk_out), .read_n(rd_n),
        .write_low_byte_n(wl_n), .write_high_byte_n(wh_n), .addr_out(a_o), .data_out(d_o),
        .wait_ticks(wait_ticks), .bus_ready_n(rdy_n), .data_in(d_i));
    // clock and hang guard
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic final_report();
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one APB transfer; answer taken at the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one external cycle, polled until done
    task automatic bus_op(input logic [7:0] cmd, input logic [15:0] a, input logic [15:0] d);
        int n;
        apb(1'b1, `EBRW_OFS_ADDR, {16'h0, a});
        apb(1'b1, `EBRW_OFS_WDATA, {16'h0, d});
        apb(1'b1, `EBRW_OFS_CMD, {24'h0, cmd});
        n = 0;
        rd = 32'h0;
        while (rd[1] !== 1'b1 && n < 100) begin
            apb(1'b0, `EBRW_OFS_STATUS, 32'h0);
            n++;
        end
        chk("done", {31'h0, rd[1]}, 32'h1);
    endtask
    task automatic t_reset();
        apb(1'b0, `EBRW_OFS_CFG, 32'h0);
        chk("cfg reset", rd, 32'h0);
        apb(1'b0, `EBRW_OFS_STATUS, 32'h0);
        chk("status reset", rd, 32'h0);
    endtask
    task automatic t_unmapped();
        apb(1'b1, 8'h18, 32'hFF);
        chk("unmapped wr err", {31'h0, er}, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped rd", {er, rd[30:0]}, 32'h80000000);
        apb(1'b0, `EBRW_OFS_CFG, 32'h0);
        chk("cfg untouched", rd, 32'h0);
    endtask
    // every wait and bus mode: write, read back, wait count seen
    task automatic t_modes();
        logic [15:0] d;
        for (int i = 0; i < 6; i++) begin
            d = 16'hC300 | 16'(i);
            wait_ticks <= mode_wait[i];
            apb(1'b1, `EBRW_OFS_CFG, {24'h0, mode_cfg[i]});
            apb(1'b0, `EBRW_OFS_CFG, 32'h0);
            chk("cfg", rd, {24'h0, mode_cfg[i]});
            bus_op(8'h06, 16'(i), d);
            bus_op(8'h07, 16'(i), 16'h0);
            apb(1'b0, `EBRW_OFS_RDATA, 32'h0);
            chk("rdata", rd, {16'h0, d});
            apb(1'b0, `EBRW_OFS_STATUS, 32'h0);
            chk("waits", {24'h0, rd[15:8]}, {24'h0, mode_wexp[i]});
        end
    endtask
    // single byte strobes leave the other byte alone
    task automatic t_bytes();
        apb(1'b1, `EBRW_OFS_CFG, 32'h10);
        bus_op(8'h02, 16'h2, 16'hFFEE);
        bus_op(8'h07, 16'h2, 16'h0);
        apb(1'b0, `EBRW_OFS_RDATA, 32'h0);
        chk("low byte", rd, 32'hC3EE);
        bus_op(8'h04, 16'h2, 16'h5A11);
        bus_op(8'h07, 16'h2, 16'h0);
        apb(1'b0, `EBRW_OFS_RDATA, 32'h0);
        chk("high byte", rd, 32'h5AEE);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_unmapped();
        t_modes();
        t_bytes();
        final_report();
    end
endmodule // ext_bus_ready_wait_control_tb_top
bind ebrw_ctrl ebrw_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .bus_ref_clock_out(bus_ref_clock_out),
    .bus_ready_n(bus_ready_n), .ale(ale), .read_n(read_n), .write_low_byte_n(write_low_byte_n),
    .write_high_byte_n(write_high_byte_n), .read_chip_sel_n(read_chip_sel_n),
    .write_chip_sel_n(write_chip_sel_n), .high_byte_enable_n(high_byte_enable_n), .data_oe(data_oe),
    .addr_out(addr_out));
